//--- src/rbx_pkg.sv
package rbx_pkg;

  // port widths
  localparam int NARROW_W = 12;
  localparam int WIDE_W = 24;
  localparam int BANKS = 2;
  localparam int CNT_W = 16;
  localparam int AVS_ADDR_W = 5;
  localparam int AVS_DATA_W = 32;

  // register byte offsets
  localparam logic [AVS_ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [AVS_ADDR_W-1:0] OFS_STATUS = 5'h04;
  localparam logic [AVS_ADDR_W-1:0] OFS_LOW_BANK = 5'h08;
  localparam logic [AVS_ADDR_W-1:0] OFS_HIGH_BANK = 5'h0C;
  localparam logic [AVS_ADDR_W-1:0] OFS_NARROW = 5'h10;
  localparam logic [AVS_ADDR_W-1:0] OFS_LOAD_COUNT = 5'h14;

  // control register fields
  localparam int CTRL_FORCE_HIZ_BIT = 0;
  localparam int CTRL_CLR_CNT_BIT = 1;
  localparam logic CTRL_FORCE_HIZ_RST = 1'b0;

  // status register fields
  localparam int STAT_NARROW_OE_BIT = 0;
  localparam int STAT_LOW_OE_BIT = 1;
  localparam int STAT_HIGH_OE_BIT = 2;
  localparam int STAT_SEL_BIT = 3;
  localparam int STAT_LOW_LOAD_BIT = 4;
  localparam int STAT_HIGH_LOAD_BIT = 5;

  // values after reset
  localparam logic [NARROW_W-1:0] BANK_RST = 12'h000;
  localparam logic [NARROW_W-1:0] NARROW_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [AVS_DATA_W-1:0] RDATA_RST = 32'h00000000;
  localparam logic WAIT_RST = 1'b1;
  localparam logic OE_RST = 1'b0;

  // pin-level control group, all active-low except the bank select
  typedef struct packed {
    logic narrow_drive_en_n;
    logic low_bank_drive_en_n;
    logic high_bank_drive_en_n;
    logic low_bank_load_n;
    logic high_bank_load_n;
    logic bank_sel;
  } rbx_ctrl_type;

  // every enable released, select low
  localparam rbx_ctrl_type CTRL_PIN_RST = 6'h3E;

  typedef struct packed {
    logic read;
    logic write;
    logic [AVS_ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [AVS_DATA_W-1:0] writedata;
  } rbx_avs_req_type;

endpackage

//--- src/rbx_bank_reg.sv
`timescale 1ns/100ps
module rbx_bank_reg #(
  parameter int WIDTH = 12
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic load_n_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);

  initial begin
    if (WIDTH < 1) begin
      $error("bank register width must be at least one");
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      data_out <= WIDTH'(rbx_pkg::BANK_RST);
    end else if (!load_n_in) begin
      data_out <= data_in;
    end
  end

  bank_load_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !load_n_in |=> data_out == $past(data_in))
    else $error("bank register missed a load");

  bank_hold_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    load_n_in |=> $stable(data_out))
    else $error("bank register changed without a load");

endmodule // rbx_bank_reg

//--- src/rbx_exchanger.sv
`timescale 1ns/100ps
module rbx_exchanger #(
  parameter int NARROW_W = rbx_pkg::NARROW_W,
  parameter int CNT_W = rbx_pkg::CNT_W
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire rbx_pkg::rbx_ctrl_type ctrl_in,
  input wire logic [NARROW_W-1:0] narrow_in,
  output logic [NARROW_W-1:0] narrow_out,
  output logic narrow_oe_out,
  input wire logic [NARROW_W-1:0] wide_low_bank_in,
  output logic [NARROW_W-1:0] wide_low_bank_out,
  output logic wide_low_bank_oe_out,
  input wire logic [NARROW_W-1:0] wide_high_bank_in,
  output logic [NARROW_W-1:0] wide_high_bank_out,
  output logic wide_high_bank_oe_out,
  input wire rbx_pkg::rbx_avs_req_type avs_req_in,
  output logic [rbx_pkg::AVS_DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out
);

  initial begin
    if (NARROW_W < 1 || NARROW_W > 16 || 2 * NARROW_W != rbx_pkg::WIDE_W) begin
      $error("narrow width must be half the wide width and fit a 16-bit field");
    end
    if (CNT_W < 1 || CNT_W > 16) begin
      $error("load counter width must be 1 to 16");
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  rbx_pkg::rbx_ctrl_type ctrl_r;
  logic [NARROW_W-1:0] bank_q [rbx_pkg::BANKS];
  logic [rbx_pkg::BANKS-1:0] bank_load_n;
  logic [NARROW_W-1:0] narrow_r;
  logic narrow_oe_r;
  logic low_oe_r;
  logic high_oe_r;
  logic force_hiz_r;
  logic clr_cnt_r;
  logic [CNT_W-1:0] low_cnt_r;
  logic [CNT_W-1:0] high_cnt_r;
  logic wait_r;
  logic [rbx_pkg::AVS_DATA_W-1:0] rdata_r;
  logic [rbx_pkg::AVS_DATA_W-1:0] rdata_nxt;
  logic acc_done;
  logic wr_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // control pins are captured every edge so the status register follows them

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r <= rbx_pkg::CTRL_PIN_RST;
    end else begin
      ctrl_r <= ctrl_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // narrow to wide: one register per bank, same narrow data into both

  assign bank_load_n = {ctrl_in.high_bank_load_n, ctrl_in.low_bank_load_n};

  for (genvar b = 0; b < rbx_pkg::BANKS; b++) begin : g_bank
    rbx_bank_reg #(
      .WIDTH(NARROW_W)
    ) u_bank (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .load_n_in(bank_load_n[b]),
      .data_in(narrow_in),
      .data_out(bank_q[b])
    );
  end

  assign wide_low_bank_out = bank_q[0];
  assign wide_high_bank_out = bank_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // wide to narrow: a single register, reloaded at every edge

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      narrow_r <= NARROW_W'(rbx_pkg::NARROW_RST);
    end else if (ctrl_in.bank_sel) begin
      narrow_r <= wide_low_bank_in;
    end else begin
      narrow_r <= wide_high_bank_in;
    end
  end

  assign narrow_out = narrow_r;

  ////////////////////////////////////////////////////////////////////////////
  // drive enables; reset stands in for the undefined power-up state and
  // releases every pin, which is what the outside aims for anyway

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      narrow_oe_r <= rbx_pkg::OE_RST;
    end else begin
      narrow_oe_r <= !ctrl_in.narrow_drive_en_n && !force_hiz_r;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_oe_r <= rbx_pkg::OE_RST;
      high_oe_r <= rbx_pkg::OE_RST;
    end else begin
      low_oe_r <= !ctrl_in.low_bank_drive_en_n && !force_hiz_r;
      high_oe_r <= !ctrl_in.high_bank_drive_en_n && !force_hiz_r;
    end
  end

  assign narrow_oe_out = narrow_oe_r;
  assign wide_low_bank_oe_out = low_oe_r;
  assign wide_high_bank_oe_out = high_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // bank load counters, wrap silently; software clears them

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_cnt_r <= CNT_W'(rbx_pkg::CNT_RST);
      high_cnt_r <= CNT_W'(rbx_pkg::CNT_RST);
    end else if (clr_cnt_r) begin
      low_cnt_r <= CNT_W'(rbx_pkg::CNT_RST);
      high_cnt_r <= CNT_W'(rbx_pkg::CNT_RST);
    end else begin
      if (!ctrl_in.low_bank_load_n) begin
        low_cnt_r <= low_cnt_r + CNT_W'(1);
      end
      if (!ctrl_in.high_bank_load_n) begin
        high_cnt_r <= high_cnt_r + CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register slave: waitrequest drops for one cycle, one cycle after request

  assign acc_done = (avs_req_in.read || avs_req_in.write) && !wait_r;
  assign wr_ctrl = acc_done && avs_req_in.write && avs_req_in.address == rbx_pkg::OFS_CTRL
    && avs_req_in.byteenable[0];

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_r <= rbx_pkg::WAIT_RST;
    end else if ((avs_req_in.read || avs_req_in.write) && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      force_hiz_r <= rbx_pkg::CTRL_FORCE_HIZ_RST;
      clr_cnt_r <= 1'b0;
    end else begin
      clr_cnt_r <= wr_ctrl && avs_req_in.writedata[rbx_pkg::CTRL_CLR_CNT_BIT];
      if (wr_ctrl) begin
        force_hiz_r <= avs_req_in.writedata[rbx_pkg::CTRL_FORCE_HIZ_BIT];
      end
    end
  end

  always_comb begin
    rdata_nxt = rbx_pkg::RDATA_RST;
    case (avs_req_in.address)
      rbx_pkg::OFS_CTRL: begin
        rdata_nxt[rbx_pkg::CTRL_FORCE_HIZ_BIT] = force_hiz_r;
      end
      rbx_pkg::OFS_STATUS: begin
        rdata_nxt[rbx_pkg::STAT_NARROW_OE_BIT] = narrow_oe_r;
        rdata_nxt[rbx_pkg::STAT_LOW_OE_BIT] = low_oe_r;
        rdata_nxt[rbx_pkg::STAT_HIGH_OE_BIT] = high_oe_r;
        rdata_nxt[rbx_pkg::STAT_SEL_BIT] = ctrl_r.bank_sel;
        rdata_nxt[rbx_pkg::STAT_LOW_LOAD_BIT] = !ctrl_r.low_bank_load_n;
        rdata_nxt[rbx_pkg::STAT_HIGH_LOAD_BIT] = !ctrl_r.high_bank_load_n;
      end
      rbx_pkg::OFS_LOW_BANK: begin
        rdata_nxt[NARROW_W-1:0] = bank_q[0];
      end
      rbx_pkg::OFS_HIGH_BANK: begin
        rdata_nxt[NARROW_W-1:0] = bank_q[1];
      end
      rbx_pkg::OFS_NARROW: begin
        rdata_nxt[NARROW_W-1:0] = narrow_r;
      end
      rbx_pkg::OFS_LOAD_COUNT: begin
        rdata_nxt[CNT_W-1:0] = low_cnt_r;
        rdata_nxt[16 +: CNT_W] = high_cnt_r;
      end
      default: begin
        rdata_nxt = rbx_pkg::RDATA_RST;
      end
    endcase
  end

  // read data is loaded on the edge that drops waitrequest and holds after
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_r <= rbx_pkg::RDATA_RST;
    end else if (avs_req_in.read && wait_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;

  ////////////////////////////////////////////////////////////////////////////

  assemble_word_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (!ctrl_in.low_bank_load_n && ctrl_in.high_bank_load_n)
    ##1 (ctrl_in.low_bank_load_n && !ctrl_in.high_bank_load_n)
    |=> wide_low_bank_out == $past(narrow_in, 2) && wide_high_bank_out == $past(narrow_in))
    else $error("two narrow words did not form one wide word");

  both_load_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !ctrl_in.low_bank_load_n && !ctrl_in.high_bank_load_n
    |=> wide_low_bank_out == wide_high_bank_out && wide_low_bank_out == $past(narrow_in))
    else $error("joint load gave different bank contents");

  both_hold_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    ctrl_in.low_bank_load_n && ctrl_in.high_bank_load_n
    |=> $stable(wide_low_bank_out) && $stable(wide_high_bank_out))
    else $error("banks changed with both loads released");

  narrow_sel_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    arst_n_in |=> narrow_out == ($past(ctrl_in.bank_sel) ? $past(wide_low_bank_in)
      : $past(wide_high_bank_in)))
    else $error("narrow register took the wrong bank");

  narrow_keep_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $past(arst_n_in) && $stable(ctrl_in.bank_sel)
    && $stable(wide_low_bank_in) && $stable(wide_high_bank_in)
    |=> $stable(narrow_out))
    else $error("narrow data moved with steady inputs");

  narrow_drive_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    ctrl_in.narrow_drive_en_n |=> !narrow_oe_out)
    else $error("narrow port driven while its enable was high");

  wide_drive_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !force_hiz_r ##0 (!ctrl_in.low_bank_drive_en_n ^ !ctrl_in.high_bank_drive_en_n)
    |=> wide_low_bank_oe_out != wide_high_bank_oe_out)
    else $error("wide enables did not gate their own banks");

  ctrl_capture_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $changed(ctrl_in.bank_sel) |=> ctrl_r.bank_sel == $past(ctrl_in.bank_sel))
    else $error("select was not registered on the edge");

  wait_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // each port's drive follows only its own enable, force_hiz overrides all

  narrow_on_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !force_hiz_r && !ctrl_in.narrow_drive_en_n |=> narrow_oe_out)
    else $error("narrow port not driven with its enable low");

  low_on_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !force_hiz_r && !ctrl_in.low_bank_drive_en_n |=> wide_low_bank_oe_out)
    else $error("low bank not driven with its enable low");

  high_on_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !force_hiz_r && !ctrl_in.high_bank_drive_en_n |=> wide_high_bank_oe_out)
    else $error("high bank not driven with its enable low");

  low_off_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    ctrl_in.low_bank_drive_en_n |=> !wide_low_bank_oe_out)
    else $error("low bank driven with its enable high");

  high_off_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    ctrl_in.high_bank_drive_en_n |=> !wide_high_bank_oe_out)
    else $error("high bank driven with its enable high");

  force_off_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    force_hiz_r |=> !narrow_oe_out && !wide_low_bank_oe_out && !wide_high_bank_oe_out)
    else $error("a port was driven while forced off");

  ////////////////////////////////////////////////////////////////////////////
  // register slave timing and the counters behind it

  wait_answer_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (avs_req_in.read || avs_req_in.write) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered after one wait cycle");

  wait_idle_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !avs_req_in.read && !avs_req_in.write |=> avs_waitrequest_out)
    else $error("waitrequest dropped without a request");

  read_hold_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !(avs_req_in.read && avs_waitrequest_out) |=> $stable(avs_readdata_out))
    else $error("read data moved outside a read");

  ctrl_write_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    wr_ctrl |=> force_hiz_r == $past(avs_req_in.writedata[rbx_pkg::CTRL_FORCE_HIZ_BIT]))
    else $error("control write did not land");

  count_clear_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    clr_cnt_r |=> low_cnt_r == CNT_W'(rbx_pkg::CNT_RST)
      && high_cnt_r == CNT_W'(rbx_pkg::CNT_RST))
    else $error("load counters not cleared");

  low_count_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !clr_cnt_r && !ctrl_in.low_bank_load_n |=> low_cnt_r == $past(low_cnt_r) + CNT_W'(1))
    else $error("low bank load not counted");

  high_count_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !clr_cnt_r && !ctrl_in.high_bank_load_n |=> high_cnt_r == $past(high_cnt_r) + CNT_W'(1))
    else $error("high bank load not counted");

  low_cnt_keep_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !clr_cnt_r && ctrl_in.low_bank_load_n |=> $stable(low_cnt_r))
    else $error("low bank counter moved without a load");

  high_cnt_keep_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !clr_cnt_r && ctrl_in.high_bank_load_n |=> $stable(high_cnt_r))
    else $error("high bank counter moved without a load");

endmodule // rbx_exchanger

//--- testbench/rbx_pin_model.sv
`timescale 1ns/100ps
module rbx_pin_model (
  input wire logic ref_clk_in,
  input wire logic drive_in,
  input wire logic [11:0] value_in,
  input wire logic dev_oe_in,
  input wire logic [11:0] dev_val_in,
  output logic [11:0] level_out
);
  logic [11:0] last_r;

  always_ff @(posedge ref_clk_in) begin
    last_r <= level_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  // an undriven line inverts its level every cycle, so a stale value matches only every other cycle
  always_comb begin
    if (dev_oe_in) begin
      level_out = dev_val_in;
    end else if (drive_in) begin
      level_out = value_in;
    end else begin
      level_out = ~last_r;
    end
  end
endmodule // rbx_pin_model

//--- testbench/tb_registered_bus_exchanger_12_to_24.sv
`timescale 1ns/100ps
module tb_registered_bus_exchanger_12_to_24;
  logic ref_clk_in;
  logic arst_n_in;
  rbx_pkg::rbx_ctrl_type ctrl_r;
  rbx_pkg::rbx_avs_req_type req_r;
  logic [11:0] host_v, low_v, high_v, n_out, l_out, h_out, exp_n;
  logic n_oe, l_oe, h_oe, wait_o, drv;
  logic [31:0] rdata, q;
  logic [2:0] prev;
  wire [11:0] narrow_pin, low_pin, high_pin;
  int failures, samples_checked, cycles;

  rbx_exchanger DUT (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ctrl_in(ctrl_r),
    .narrow_in(narrow_pin), .narrow_out(n_out), .narrow_oe_out(n_oe),
    .wide_low_bank_in(low_pin), .wide_low_bank_out(l_out), .wide_low_bank_oe_out(l_oe),
    .wide_high_bank_in(high_pin), .wide_high_bank_out(h_out), .wide_high_bank_oe_out(h_oe),
    .avs_req_in(req_r), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o));
  rbx_pin_model host_m (.ref_clk_in(ref_clk_in), .drive_in(drv), .value_in(host_v),
    .dev_oe_in(n_oe), .dev_val_in(n_out), .level_out(narrow_pin));
  rbx_pin_model low_m (.ref_clk_in(ref_clk_in), .drive_in(drv), .value_in(low_v),
    .dev_oe_in(l_oe), .dev_val_in(l_out), .level_out(low_pin));
  rbx_pin_model high_m (.ref_clk_in(ref_clk_in), .drive_in(drv), .value_in(high_v),
    .dev_oe_in(h_oe), .dev_val_in(h_out), .level_out(high_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // control is sampled at two edges; the second repeats the first, so the load counters count each load twice
  task automatic go(input rbx_pkg::rbx_ctrl_type c, input logic [11:0] h);
    @(posedge ref_clk_in);
    ctrl_r <= c;
    host_v <= h;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask

  // request stays up until the edge at which waitrequest is seen low
  task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    req_r <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
    @(posedge ref_clk_in);
    while (wait_o !== 1'b0) begin
      @(posedge ref_clk_in);
    end
    q = rdata;
    req_r <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    arst_n_in = 1'b0;
    ctrl_r = rbx_pkg::CTRL_PIN_RST;
    req_r = '0;
    drv = 1'b1;
    host_v = 12'h000;
    low_v = 12'h123;
    high_v = 12'h456;
    repeat (10) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    @(negedge ref_clk_in);
    check({n_oe, l_oe, h_oe}, 3'h0);
    go(6'h3A, 12'hA5C);
    check(l_out, 12'hA5C);
    go(6'h3C, 12'h3B7);
    check({h_out, l_out}, 24'h3B7A5C);
    go(6'h3E, 12'hFFF);
    check({h_out, l_out}, 24'h3B7A5C);
    go(6'h38, 12'h6C1);
    check({h_out, l_out}, 24'h6C16C1);
    $display("test narrow to wide done");
    go(6'h1F, 12'h000);
    check(n_out, 12'h123);
    check(narrow_pin, 12'h123);
    check(low_pin, 12'h123);
    go(6'h1E, 12'h000);
    check(n_out, 12'h456);
    @(posedge ref_clk_in);
    high_v <= 12'h789;
    @(negedge ref_clk_in);
    check(n_out, 12'h456);
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check(n_out, 12'h789);
    $display("test wide to narrow done");
    prev = 3'h4;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_in);
      ctrl_r <= {i[2:0], 3'h7};
      host_v <= 12'h5A5;
      @(negedge ref_clk_in);
      check({n_oe, l_oe, h_oe}, prev);
      // select is high, so the narrow register takes the low bank pin level
      exp_n = prev[1] ? 12'h6C1 : 12'h123;
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      prev = ~i[2:0];
      check({n_oe, l_oe, h_oe}, prev);
      check(n_out, exp_n);
      check(narrow_pin, prev[2] ? exp_n : 12'h5A5);
    end
    $display("test output enables done");
    go(6'h07, 12'h000);
    avs(1'b0, rbx_pkg::OFS_STATUS, 32'h0);
    check(q, 32'h0000000F);
    avs(1'b0, rbx_pkg::OFS_LOW_BANK, 32'h0);
    check(q, 32'h000006C1);
    avs(1'b1, rbx_pkg::OFS_CTRL, 32'h00000001);
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check({n_oe, l_oe, h_oe}, 3'h0);
    avs(1'b0, 5'h1C, 32'h0);
    check(q, 32'h00000000);
    avs(1'b1, rbx_pkg::OFS_CTRL, 32'h00000000);
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check({n_oe, l_oe, h_oe}, 3'h7);
    avs(1'b0, rbx_pkg::OFS_HIGH_BANK, 32'h0);
    check(q, 32'h000006C1);
    avs(1'b0, rbx_pkg::OFS_NARROW, 32'h0);
    check(q, 32'h000006C1);
    avs(1'b0, rbx_pkg::OFS_LOAD_COUNT, 32'h0);
    check(q, 32'h00040004);
    avs(1'b1, rbx_pkg::OFS_CTRL, 32'h00000002);
    avs(1'b0, rbx_pkg::OFS_LOAD_COUNT, 32'h0);
    check(q, 32'h00000000);
    $display("test register bus done");
    end_sim();
  end
endmodule // tb_registered_bus_exchanger_12_to_24
